// ### rtl/lrfa_pkg.sv
// Constants, field layouts and carriers of the loop-back return frame assembler
package lrfa_pkg;

	// ------------------------------------------------------------
	// Block geometry
	// ------------------------------------------------------------
	localparam int BLK_W = 432;
	localparam int FLAG_W = 3;
	localparam int AACH_W = 14;
	localparam int CH1_W = 268;
	localparam int CH2_W = 137;
	localparam int TYPE_W = 5;
	localparam int ECC_W = 30;
	localparam int FIFO_DEPTH = 8;

	// ------------------------------------------------------------
	// Error flag positions, counted from the last bit of the block
	// ------------------------------------------------------------
	localparam int FLAG_FIRST_POS = 0;
	localparam int FLAG_SECOND_POS = 1;
	localparam int FLAG_ACCESS_POS = 2;

	// ------------------------------------------------------------
	// Field lengths per burst type
	// ------------------------------------------------------------
	localparam int T2_DATA = 268;
	localparam int T2_FILL = 147;
	localparam int T3_BSCH = 60;
	localparam int T3_FILL1 = 156;
	localparam int T3_HD = 124;
	localparam int T3_FILL2 = 75;
	localparam int T4_DATA = 144;
	localparam int T4_FILL = 271;
	localparam int T8_DATA = 268;
	localparam int T8_FILL = 161;
	localparam int T9_STCH = 124;
	localparam int T9_FILL1 = 92;
	localparam int T9_FILL2 = 89;
	localparam int T10_DATA = 144;
	localparam int T10_FILL = 285;
	localparam int T11_HU = 92;
	localparam int T11_FILL1 = 124;
	localparam int T11_FILL2 = 121;
	localparam int T15_SPEECH = 137;
	localparam int T15_FILL1 = 79;
	localparam int T15_FILL2 = 62;

	// ------------------------------------------------------------
	// Requested test burst type codes
	// ------------------------------------------------------------
	localparam logic [TYPE_W-1:0] BT_DL_SCHF = 5'h02;
	localparam logic [TYPE_W-1:0] BT_DL_BSCH_HD = 5'h03;
	localparam logic [TYPE_W-1:0] BT_DL_TCH24 = 5'h04;
	localparam logic [TYPE_W-1:0] BT_UL_TCH72 = 5'h07;
	localparam logic [TYPE_W-1:0] BT_UL_SCHF = 5'h08;
	localparam logic [TYPE_W-1:0] BT_UL_STCH = 5'h09;
	localparam logic [TYPE_W-1:0] BT_UL_TCH24 = 5'h0a;
	localparam logic [TYPE_W-1:0] BT_UL_SCHHU = 5'h0b;
	localparam logic [TYPE_W-1:0] BT_DL_SPEECH = 5'h0f;

	// ------------------------------------------------------------
	// Return slot window and reset values
	// ------------------------------------------------------------
	localparam logic [2:0] TN_RETURN = 3'h1;
	localparam logic [4:0] FN_FIRST = 5'h01;
	localparam logic [4:0] FN_LAST = 5'h11;
	localparam logic [ECC_W-1:0] ECC_RST = 30'h0000_0000;
	localparam logic [BLK_W-1:0] BLK_RST = '0;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	// Decoded receive result; every field has received bit index 1 at its MSB
	typedef struct packed {
		logic [TYPE_W-1:0] burst_type;
		logic burst_missing;
		logic subslot_one_present;
		logic subslot_two_present;
		logic first_block_error_flag;
		logic second_block_error_flag;
		logic access_assign_error_flag;
		logic [AACH_W-1:0] aach_bits;
		logic [CH1_W-1:0] first_burst_block;
		logic [CH2_W-1:0] second_burst_block;
		logic [BLK_W-1:0] raw_bits;
	} lrfa_rx_t;

	// Assembled return block with the scrambling code it must be sent with
	typedef struct packed {
		logic [BLK_W-1:0] block;
		logic [ECC_W-1:0] scramble_code;
	} lrfa_tx_t;

	// Places the three flags at their positions in the tail of the block
	function automatic logic [FLAG_W-1:0] lrfa_flags(input logic access_f, input logic second_f,
		input logic first_f);
		logic [FLAG_W-1:0] f;
		f = '0;
		f[FLAG_ACCESS_POS] = access_f;
		f[FLAG_SECOND_POS] = second_f;
		f[FLAG_FIRST_POS] = first_f;
		return f;
	endfunction : lrfa_flags

endpackage : lrfa_pkg

// ### rtl/lrfa_fifo.sv
// Parameterised FIFO with registered read data for assembled return blocks
`timescale 1ns/1ps
module lrfa_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Fill side
	input wire logic wr_valid_i,
	input wire logic [WIDTH-1:0] wr_data_i,
	output logic wr_ready_o,
	// Drain side
	output logic rd_valid_o,
	output logic [WIDTH-1:0] rd_data_o,
	input wire logic rd_ready_i
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	// ------------------------------------------------------------
	// Storage and pointers
	// ------------------------------------------------------------
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wr_ptr_ff;
	logic [AW-1:0] rd_ptr_ff;
	logic [CW-1:0] cnt_ff;
	logic out_valid_ff;
	logic [WIDTH-1:0] out_data_ff;

	// Handshake decode; the output register counts as one extra slot
	wire push = wr_valid_i && wr_ready_o;
	wire load = (cnt_ff != '0) && (!out_valid_ff || rd_ready_i);
	wire [AW-1:0] wr_ptr_inc = (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
	wire [AW-1:0] rd_ptr_inc = (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;

	assign wr_ready_o = (cnt_ff != CW'(DEPTH));
	assign rd_valid_o = out_valid_ff;
	assign rd_data_o = out_data_ff;

	// Memory write; no reset needed on data storage
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_ff[wr_ptr_ff] <= wr_data_i;
		end
	end

	// Pointer and count bookkeeping
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			cnt_ff <= '0;
		end else begin
			if (push) begin
				wr_ptr_ff <= wr_ptr_inc;
			end
			if (load) begin
				rd_ptr_ff <= rd_ptr_inc;
			end
			cnt_ff <= cnt_ff + CW'(push) - CW'(load);
		end
	end

	// Registered head word; drops valid once taken with nothing behind it
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			out_valid_ff <= 1'b0;
			out_data_ff <= '0;
		end else if (load) begin
			out_valid_ff <= 1'b1;
			out_data_ff <= mem_ff[rd_ptr_ff];
		end else if (rd_ready_i) begin
			out_valid_ff <= 1'b0;
		end
	end

endmodule : lrfa_fifo

// ### rtl/lrfa_top.sv
// Loop-back return frame assembler: packs decoded channels into the 432-bit return block
//
// Overview of operation
// - Downlink type 2: 268 SCH/F bits, 147 zeros, 14 AACH, flags; second flag zero.
// - Downlink type 3: 60 BSCH, 156 zeros, 124 SCH/HD, 75 zeros, AACH, flags.
// - Type 3 BSCH bits come from first block of the synchronisation burst, fully decoded.
// - Type 3 drives all three error flags; every fill position is zero.
// - Type 3 keeps the existing colour code; received BSCH content never changes it.
// - Downlink type 4: 144 bits, 271 zeros, AACH, flags; only access flag driven.
// - Uplink type 7 returns all 432 descrambled bits unchanged, no fill, no flags.
// - Uplink type 8: 268 SCH/F bits, 161 zeros, flags; only first flag driven.
// - Uplink type 9: two STCH blocks with 92 and 89 zeros; access flag zero.
// - Uplink type 10: 144 bits, 285 zeros, three flags all zero.
// - Uplink type 11: 92 bits, 124 zeros, 92 bits, 121 zeros, flags; access zero.
// - Type 11 subslot two data and flag only when present; first flag when subslot one present.
// - Downlink type 15: 137, 79 zeros, 137, 62 zeros, AACH, flags; second flag zero.
// - Access-assignment field carries the 14 decoded broadcast block bits.
// - Each error flag is one bit: 1 for detected error, 0 otherwise.
// - Missing expected burst returns all data zero and all error flags one.
// - The assembled block leaves only for scrambling, with no further coding.
// - Return blocks go out only in timeslot 1 of frames 1 to 17.
`timescale 1ns/1ps
module lrfa_top
	import lrfa_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Decoded channels from the receive decoders
	input wire logic rx_valid_i,
	input wire lrfa_rx_t rx_i,
	output logic rx_ready_o,
	// Extended colour code from the synchronisation procedure
	input wire logic cc_load_i,
	input wire logic [ECC_W-1:0] cc_i,
	// Slot timing from the frame counter
	input wire logic slot_start_i,
	input wire logic [2:0] tn_i,
	input wire logic [4:0] fn_i,
	// Return block towards the scrambler
	output logic tx_valid_o,
	output lrfa_tx_t tx_o,
	input wire logic tx_ready_i,
	// Status
	output logic unsupported_o
);

	// ------------------------------------------------------------
	// Field views of the incoming decoded result
	// ------------------------------------------------------------
	// All fields are MSB-aligned so index one of every channel leads
	wire [T2_DATA-1:0] f_schf = rx_i.first_burst_block[CH1_W-1 -: T2_DATA];
	// For type 3 the first-block input holds the decoded sync burst block
	wire [T3_BSCH-1:0] f_bsch = rx_i.first_burst_block[CH1_W-1 -: T3_BSCH];
	wire [T3_HD-1:0] f_schhd = rx_i.second_burst_block[CH2_W-1 -: T3_HD];
	wire [T4_DATA-1:0] f_tch24 = rx_i.first_burst_block[CH1_W-1 -: T4_DATA];
	wire [T9_STCH-1:0] f_stch1 = rx_i.first_burst_block[CH1_W-1 -: T9_STCH];
	wire [T9_STCH-1:0] f_stch2 = rx_i.second_burst_block[CH2_W-1 -: T9_STCH];
	wire [T11_HU-1:0] f_hu1 = rx_i.first_burst_block[CH1_W-1 -: T11_HU];
	wire [T11_HU-1:0] f_hu2 = rx_i.second_burst_block[CH2_W-1 -: T11_HU];
	wire [T15_SPEECH-1:0] f_spa = rx_i.first_burst_block[CH1_W-1 -: T15_SPEECH];
	wire [T15_SPEECH-1:0] f_spb = rx_i.second_burst_block[CH2_W-1 -: T15_SPEECH];
	wire [AACH_W-1:0] f_aach = rx_i.aach_bits;

	// Short names for the three receiver error indications
	wire e_first = rx_i.first_block_error_flag;
	wire e_second = rx_i.second_block_error_flag;
	wire e_access = rx_i.access_assign_error_flag;

	// ------------------------------------------------------------
	// Subslot presence for the half-slot uplink type
	// ------------------------------------------------------------
	// An absent subslot contributes zeros and a clear flag
	wire [T11_HU-1:0] hu1_bits = rx_i.subslot_one_present ? f_hu1 : '0;
	wire [T11_HU-1:0] hu2_bits = rx_i.subslot_two_present ? f_hu2 : '0;
	wire hu1_err = rx_i.subslot_one_present && e_first;
	wire hu2_err = rx_i.subslot_two_present && e_second;

	// ------------------------------------------------------------
	// Error flag tails per type
	// ------------------------------------------------------------
	wire [FLAG_W-1:0] fl_t2 = lrfa_flags(e_access, 1'b0, e_first);
	wire [FLAG_W-1:0] fl_t3 = lrfa_flags(e_access, e_second, e_first);
	wire [FLAG_W-1:0] fl_t4 = lrfa_flags(e_access, 1'b0, 1'b0);
	wire [FLAG_W-1:0] fl_t8 = lrfa_flags(1'b0, 1'b0, e_first);
	wire [FLAG_W-1:0] fl_t9 = lrfa_flags(1'b0, e_second, e_first);
	wire [FLAG_W-1:0] fl_t10 = lrfa_flags(1'b0, 1'b0, 1'b0);
	wire [FLAG_W-1:0] fl_t11 = lrfa_flags(1'b0, hu2_err, hu1_err);
	wire [FLAG_W-1:0] fl_t15 = lrfa_flags(e_access, 1'b0, e_first);
	wire [FLAG_W-1:0] fl_all = lrfa_flags(1'b1, 1'b1, 1'b1);

	// ------------------------------------------------------------
	// Field layouts, first field in the MSB
	// ------------------------------------------------------------
	wire [BLK_W-1:0] lay_t2 = {f_schf, {T2_FILL{1'b0}}, f_aach, fl_t2};
	wire [BLK_W-1:0] lay_t3 = {f_bsch, {T3_FILL1{1'b0}}, f_schhd, {T3_FILL2{1'b0}},
		f_aach, fl_t3};
	wire [BLK_W-1:0] lay_t4 = {f_tch24, {T4_FILL{1'b0}}, f_aach, fl_t4};
	wire [BLK_W-1:0] lay_t7 = rx_i.raw_bits;
	wire [BLK_W-1:0] lay_t8 = {f_schf, {T8_FILL{1'b0}}, fl_t8};
	wire [BLK_W-1:0] lay_t9 = {f_stch1, {T9_FILL1{1'b0}}, f_stch2, {T9_FILL2{1'b0}}, fl_t9};
	wire [BLK_W-1:0] lay_t10 = {f_tch24, {T10_FILL{1'b0}}, fl_t10};
	wire [BLK_W-1:0] lay_t11 = {hu1_bits, {T11_FILL1{1'b0}}, hu2_bits, {T11_FILL2{1'b0}},
		fl_t11};
	wire [BLK_W-1:0] lay_t15 = {f_spa, {T15_FILL1{1'b0}}, f_spb, {T15_FILL2{1'b0}},
		f_aach, fl_t15};

	// Missing burst: data zero, flags one; the flagless type stays all zero
	wire is_t7 = (rx_i.burst_type == BT_UL_TCH72);
	wire [BLK_W-1:0] lay_miss = is_t7 ? BLK_RST : {{(BLK_W-FLAG_W){1'b0}}, fl_all};

	// ------------------------------------------------------------
	// Layout selection by requested burst type
	// ------------------------------------------------------------
	wire bt_t2 = (rx_i.burst_type == BT_DL_SCHF);
	wire bt_t3 = (rx_i.burst_type == BT_DL_BSCH_HD);
	wire bt_t4 = (rx_i.burst_type == BT_DL_TCH24);
	wire bt_t8 = (rx_i.burst_type == BT_UL_SCHF);
	wire bt_t9 = (rx_i.burst_type == BT_UL_STCH);
	wire bt_t10 = (rx_i.burst_type == BT_UL_TCH24);
	wire bt_t11 = (rx_i.burst_type == BT_UL_SCHHU);
	wire bt_t15 = (rx_i.burst_type == BT_DL_SPEECH);
	wire bt_known = bt_t2 | bt_t3 | bt_t4 | is_t7 | bt_t8 | bt_t9 | bt_t10 | bt_t11 | bt_t15;

	wire [BLK_W-1:0] lay_type =
		bt_t2 ? lay_t2 :
		bt_t3 ? lay_t3 :
		bt_t4 ? lay_t4 :
		is_t7 ? lay_t7 :
		bt_t8 ? lay_t8 :
		bt_t9 ? lay_t9 :
		bt_t10 ? lay_t10 :
		bt_t11 ? lay_t11 :
		bt_t15 ? lay_t15 : BLK_RST;

	wire [BLK_W-1:0] lay_sel = rx_i.burst_missing ? lay_miss : lay_type;

	// ------------------------------------------------------------
	// Scrambling code holder
	// ------------------------------------------------------------
	// Loaded only from the synchronisation procedure; the decoded BSCH of a
	// type 3 loop-back is pseudo-random and has no path into this register
	logic [ECC_W-1:0] cc_ff;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cc_ff <= ECC_RST;
		end else if (cc_load_i) begin
			cc_ff <= cc_i;
		end
	end

	// ------------------------------------------------------------
	// Assembly stage
	// ------------------------------------------------------------
	// One registered word between decoders and FIFO; it stalls on a full FIFO,
	// and that stall reaches the decoders through rx_ready_o
	logic asm_valid_ff;
	lrfa_tx_t asm_ff;
	logic rx_ready_ff;
	logic unsupported_ff;
	logic fifo_wr_ready;

	wire asm_drain = asm_valid_ff && fifo_wr_ready;
	wire rx_take = rx_valid_i && rx_ready_ff;
	wire rx_keep = rx_take && bt_known;
	wire nxt_asm_valid = rx_keep || (asm_valid_ff && !asm_drain);

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			asm_valid_ff <= 1'b0;
			asm_ff <= '0;
			rx_ready_ff <= 1'b1;
			unsupported_ff <= 1'b0;
		end else begin
			asm_valid_ff <= nxt_asm_valid;
			rx_ready_ff <= !nxt_asm_valid;
			unsupported_ff <= rx_take && !bt_known;
			if (rx_keep) begin
				asm_ff.block <= lay_sel;
				asm_ff.scramble_code <= cc_ff;
			end
		end
	end

	assign rx_ready_o = rx_ready_ff;
	assign unsupported_o = unsupported_ff;

	// ------------------------------------------------------------
	// Block FIFO
	// ------------------------------------------------------------
	// Eight blocks, plus one in the output register, buffer results while the transmitter is busy
	logic fifo_rd_valid;
	lrfa_tx_t fifo_rd_data;
	logic fifo_rd_ready;

	lrfa_fifo #(
		.WIDTH($bits(lrfa_tx_t)),
		.DEPTH(DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wr_valid_i(asm_valid_ff),
		.wr_data_i(asm_ff),
		.wr_ready_o(fifo_wr_ready),
		.rd_valid_o(fifo_rd_valid),
		.rd_data_o(fifo_rd_data),
		.rd_ready_i(fifo_rd_ready)
	);

	// ------------------------------------------------------------
	// Return slot gating
	// ------------------------------------------------------------
	// At most one block per slot start, and only in the permitted slots
	logic tx_valid_ff;
	lrfa_tx_t tx_ff;

	wire slot_ok = (tn_i == TN_RETURN) && (fn_i >= FN_FIRST) && (fn_i <= FN_LAST);
	wire tx_free = !tx_valid_ff || tx_ready_i;
	assign fifo_rd_ready = slot_start_i && slot_ok && tx_free;
	wire tx_launch = fifo_rd_ready && fifo_rd_valid;

	// ------------------------------------------------------------
	// Output register
	// ------------------------------------------------------------
	// The block goes straight to the scrambler: no coding stage follows
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			tx_valid_ff <= 1'b0;
			tx_ff <= '0;
		end else if (tx_launch) begin
			tx_valid_ff <= 1'b1;
			tx_ff <= fifo_rd_data;
		end else if (tx_ready_i) begin
			tx_valid_ff <= 1'b0;
		end
	end

	assign tx_valid_o = tx_valid_ff;
	assign tx_o = tx_ff;

endmodule : lrfa_top

// ### bench/lrfa_top_checker.sv
// Port-level concurrent checks for the loop-back return frame assembler
`timescale 1ns/1ps
module lrfa_top_checker
	import lrfa_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Receive side
	input wire logic rx_valid_i,
	input wire lrfa_rx_t rx_i,
	input wire logic rx_ready_o,
	// Colour code and slot timing
	input wire logic cc_load_i,
	input wire logic [ECC_W-1:0] cc_i,
	input wire logic slot_start_i,
	input wire logic [2:0] tn_i,
	input wire logic [4:0] fn_i,
	// Return side
	input wire logic tx_valid_o,
	input wire lrfa_tx_t tx_o,
	input wire logic tx_ready_i,
	input wire logic unsupported_o
);
	// ----------------
	// Decodes
	// ----------------
	logic sup;
	logic take;
	logic win;
	assign sup = rx_i.burst_type inside {5'h02, 5'h03, 5'h04, 5'h07, 5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0f};
	assign take = rx_valid_i && rx_ready_o;
	// Only slot 1 of frames 1 to 17 may launch a block
	assign win = slot_start_i && tn_i == TN_RETURN && fn_i >= FN_FIRST && fn_i <= FN_LAST;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// ----------------
	// Assertions
	// ----------------
	AST_LAUNCH_WIN: assert property ($rose(tx_valid_o) |-> $past(win))
		else $error("return block launched outside the return slot window");
	AST_NO_LAUNCH: assert property (!tx_valid_o && !win |=> !tx_valid_o)
		else $error("return block appeared without a slot start");
	AST_TX_DROP: assert property (tx_valid_o && tx_ready_i && !win |=> !tx_valid_o)
		else $error("return block stayed valid after acceptance");
	AST_TX_HOLD: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_o))
		else $error("return block changed while waiting for the transmitter");
	AST_TAKE_DROP: assert property (take && sup |=> !rx_ready_o)
		else $error("ready stayed high after a supported result was taken");
	AST_UNSUP_PULSE: assert property (take && !sup |-> ##[1:2] unsupported_o)
		else $error("unsupported result gave no status pulse");
	AST_UNSUP_CAUSE: assert property ($rose(unsupported_o) |-> $past(take && !sup) || $past(take && !sup, 2))
		else $error("status pulse without an unsupported result");
	AST_READY_BACK: assert property (!rx_ready_o |-> ##[1:1000] rx_ready_o)
		else $error("receive side never became ready again");
endmodule : lrfa_top_checker

bind lrfa_top lrfa_top_checker #(.DEPTH(DEPTH)) u_lrfa_top_checker (.clk_i(clk_i), .rst_i(rst_i),
	.rx_valid_i(rx_valid_i), .rx_i(rx_i), .rx_ready_o(rx_ready_o), .cc_load_i(cc_load_i), .cc_i(cc_i),
	.slot_start_i(slot_start_i), .tn_i(tn_i), .fn_i(fn_i), .tx_valid_o(tx_valid_o), .tx_o(tx_o),
	.tx_ready_i(tx_ready_i), .unsupported_o(unsupported_o));

// ### bench/lrfa_tx_partner.sv
// Return transmit path model: slot timing and a block sink that can stall
`timescale 1ns/1ps
module lrfa_tx_partner (
	// Clock and stall mode
	input wire logic clk_i,
	input wire logic stall_i,
	// Slot timing towards the assembler
	output logic slot_start_o = 1'h0,
	output logic [2:0] tn_o = 3'h4,
	output logic [4:0] fn_o = 5'h12,
	// Block acceptance
	input wire logic tx_valid_i,
	output logic tx_ready_o = 1'h0
);
	logic [1:0] sym_ff = 2'h0;

	// ----------------
	// Slot counter
	// ----------------
	// One slot every four cycles; frame 18 is kept so the closed frame is exercised
	always @(negedge clk_i) begin
		sym_ff <= sym_ff + 2'h1;
		slot_start_o <= (sym_ff == 2'h3);
		if (sym_ff == 2'h3) begin
			tn_o <= (tn_o == 3'h4) ? 3'h1 : tn_o + 3'h1;
			if (tn_o == 3'h4) begin
				fn_o <= (fn_o == 5'h12) ? 5'h01 : fn_o + 5'h01;
			end
		end
		// A stalling sink accepts only now and then, so blocks pile up
		tx_ready_o <= !stall_i || (tx_valid_i && $urandom_range(0, 3) == 0);
	end
endmodule : lrfa_tx_partner

// ### bench/testbench.sv
// Self-checking bench for the loop-back return frame assembler
`timescale 1ns/1ps
module testbench
	import lrfa_pkg::*;
;
	logic clk_i = 1'h0;
	logic rst_i = 1'h1;
	logic rx_valid_i = 1'h0;
	lrfa_rx_t rx_i = '0;
	logic cc_load_i = 1'h0;
	logic [ECC_W-1:0] cc_i = '0;
	logic stall = 1'h0;
	logic rx_ready_o;
	logic slot_start_i;
	logic tx_valid_o;
	logic tx_ready_i;
	logic unsupported_o;
	logic [2:0] tn_i;
	logic [4:0] fn_i;
	lrfa_tx_t tx_o;
	lrfa_tx_t exp_q[$];
	logic [ECC_W-1:0] cc_cur = '0;
	int errors = 0;
	int checked = 0;
	int uns_exp = 0;
	int uns_seen = 0;
	int maxw = 0;
	localparam logic [4:0] SUP[9] = '{5'h02, 5'h03, 5'h04, 5'h07, 5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0f};
	localparam logic [4:0] BAD[6] = '{5'h00, 5'h01, 5'h05, 5'h10, 5'h13, 5'h1f};

	always #25 clk_i = ~clk_i;

	lrfa_top #(.DEPTH(8)) u_lrfa_top (.clk_i(clk_i), .rst_i(rst_i), .rx_valid_i(rx_valid_i), .rx_i(rx_i),
		.rx_ready_o(rx_ready_o), .cc_load_i(cc_load_i), .cc_i(cc_i), .slot_start_i(slot_start_i), .tn_i(tn_i),
		.fn_i(fn_i), .tx_valid_o(tx_valid_o), .tx_o(tx_o), .tx_ready_i(tx_ready_i), .unsupported_o(unsupported_o));
	lrfa_tx_partner u_lrfa_tx_partner (.clk_i(clk_i), .stall_i(stall), .slot_start_o(slot_start_i), .tn_o(tn_i),
		.fn_o(fn_i), .tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready_i));

	// ----------------
	// Helpers
	// ----------------
	task automatic check(input logic [BLK_W+ECC_W-1:0] seen, input logic [BLK_W+ECC_W-1:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask : check

	task automatic finish_test();
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : finish_test

	// Expected return block; channel fields are taken from their top bits
	function automatic logic [BLK_W-1:0] exp_blk(input lrfa_rx_t r);
		logic [267:0] a;
		logic [136:0] b;
		logic [13:0] c;
		logic e1;
		logic e2;
		logic e3;
		logic s1;
		logic s2;
		a = r.first_burst_block;
		b = r.second_burst_block;
		c = r.aach_bits;
		{e1, e2, e3} = {r.first_block_error_flag, r.second_block_error_flag, r.access_assign_error_flag};
		{s1, s2} = {r.subslot_one_present, r.subslot_two_present};
		if (r.burst_missing) return (r.burst_type == 5'h07) ? '0 : 432'h7;
		case (r.burst_type)
		5'h02: return {a, 147'h0, c, e3, 1'h0, e1};
		5'h03: return {a[267-:60], 156'h0, b[136-:124], 75'h0, c, e3, e2, e1};
		5'h04: return {a[267-:144], 271'h0, c, e3, 2'h0};
		5'h08: return {a, 161'h0, 2'h0, e1};
		5'h09: return {a[267-:124], 92'h0, b[136-:124], 89'h0, 1'h0, e2, e1};
		5'h0a: return {a[267-:144], 288'h0};
		5'h0b: return {s1 ? a[267-:92] : 92'h0, 124'h0, s2 ? b[136-:92] : 92'h0, 121'h0,
			1'h0, e2 & s2, e1 & s1};
		5'h0f: return {a[267-:137], 79'h0, b, 62'h0, c, e3, 1'h0, e1};
		default: return r.raw_bits;
		endcase
	endfunction : exp_blk

	// Offers one random result and returns once it has been taken
	task automatic send(input logic [4:0] t, input logic miss);
		lrfa_rx_t r;
		int n;
		for (n = 0; n < 27; n++) r = {r[829:0], $urandom()};
		r.burst_type = t;
		r.burst_missing = miss;
		if (t inside {SUP}) exp_q.push_back({exp_blk(r), cc_cur});
		else uns_exp++;
		rx_i = r;
		rx_valid_i = 1'h1;
		for (n = 0; n < 3000 && rx_ready_o !== 1'h1; n++) @(negedge clk_i);
		if (n > maxw) maxw = n;
		@(negedge clk_i);
	endtask : send

	task automatic drain(input string name);
		int n;
		rx_valid_i = 1'h0;
		for (n = 0; n < 20000 && exp_q.size() != 0; n++) @(negedge clk_i);
		repeat (4) @(negedge clk_i);
		check(exp_q.size(), 0);
		$display("test %s done, errors %0d", name, errors);
	endtask : drain

	// Loaded only while no result is offered, so the expected code is unambiguous
	task automatic load_cc();
		cc_i = ECC_W'($urandom());
		cc_load_i = 1'h1;
		@(negedge clk_i);
		cc_load_i = 1'h0;
		cc_cur = cc_i;
	endtask : load_cc

	// ----------------
	// Scoreboard
	// ----------------
	always @(posedge clk_i) begin
		if (!rst_i && tx_valid_o === 1'h1 && tx_ready_i === 1'h1) begin
			// A block with nothing expected is a mismatch even if it holds unknowns
			if (exp_q.size() != 0) begin
				check(tx_o, exp_q.pop_front());
			end else begin
				check(1, 0);
			end
		end
		if (unsupported_o === 1'h1) uns_seen++;
	end

	// ----------------
	// Tests
	// ----------------
	initial begin
		void'($urandom(57));
		repeat (3) @(negedge clk_i);
		rst_i = 1'h0;
		load_cc();
		for (int k = 0; k < 4; k++) foreach (SUP[i]) send(SUP[i], 1'h0);
		drain("layouts");
		foreach (SUP[i]) send(SUP[i], 1'h1);
		drain("missing");
		// Random sync content must never move the scrambling code
		for (int k = 0; k < 2; k++) begin
			load_cc();
			repeat (3) send(BT_DL_BSCH_HD, 1'h0);
			drain("colour");
		end
		foreach (BAD[i]) send(BAD[i], 1'h0);
		drain("unsupported");
		check(uns_seen, uns_exp);
		// Stalled sink: the buffer fills and the receive side refuses
		stall = 1'h1;
		maxw = 0;
		repeat (14) send(SUP[$urandom_range(0, 8)], 1'h0);
		drain("fill");
		check(maxw > 8, 1);
		finish_test();
	end

	// Watchdog
	initial begin
		#(50 * 60000);
		errors++;
		finish_test();
	end
endmodule : testbench
